// file: src/eetws_mem.sv
// nonvolatile byte array: one write port, one registered read port
// assumes the caller sequences writes; no reset on the array itself
`timescale 1ns/1ps
`default_nettype none
module eetws_mem
  import eetws_pkg::*;
#(
  parameter int unsigned AW = ADDR_W,
  parameter int unsigned DW = DATA_W
)
(
  input  wire logic          ref_clk,
  input  wire logic          rst_b,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output var  logic [DW-1:0] rd_data
);

  logic [DW-1:0] cells [0:(1<<AW)-1];

  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      cells[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= cells[rd_addr];
    end
  end

endmodule
`default_nettype wire

// file: src/eetws_pkg.sv
// package for the two-wire memory slave: constants, states, helpers
// assumes a single 10 MHz core clock sampling the bus pins
package eetws_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;
  // programming cycle length; no figure is fixed, plain default
  localparam int unsigned WRITE_TIME_NS = 10000000;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned PAGE_LSB_W    = 3;
  localparam logic [3:0]  PAGE_BYTES    = 4'h8;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam int unsigned FIFO_DEPTH    = 2;
  // device type code; value is arbitrary
  localparam logic [5:0]  DEV_TYPE_DEF  = 6'h2A;
  localparam logic        SDA_LOW       = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEVW,
    ST_MADDR,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_RACK,
    ST_PROG
  } eetws_state_e;

  // least time to whole clock cycles, never below one
  function automatic int unsigned eetws_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction

  // next address inside the same page
  function automatic logic [7:0] eetws_page_inc(input logic [7:0] a);
    return {a[7:3], 3'(a[2:0] + 3'h1)};
  endfunction

endpackage

// file: src/eetws_slave.sv
// two-wire slave front end of a 256-byte nonvolatile memory
// assumes scl and sda come from pins; the bench resolves the open-drain wire
//
// Summary of operation
// - data falling while clock high is a start; needed before commands
// - data rising while clock high is a stop ending the transfer
// - stop after a read puts the device into standby
// - device pulls data low on ninth clock for each received byte
// - standby after power-on, after stop, after internal work ends
// - address word: six-bit type code, select bit, direction bit, msb first
// - direction high means read, low means write
// - acknowledge only on type and select match, else back to standby
// - write mode: memory address then data bytes, each acknowledged
// - stop after write data starts the timed page programming
// - serial inputs ignored while programming runs
// - page write: up to seven more bytes after the first
// - write address wraps inside its page, never crosses it
// - staged bytes committed only when write ends with a stop
// - no acknowledge to polling while programming; proceed after
// - address register holds last address plus one; reads wrap at top, writes wrap inside their page
// - current read sends byte at internal address; master nacks, stops
// - keep sending successive bytes while master acknowledges, wrap at top
// - 32 pages of eight: high five bits page, low three bits byte
// - after master nack the device releases the data line
`timescale 1ns/1ps
`default_nettype none
module eetws_slave
  import eetws_pkg::*;
#(
  parameter int unsigned T_WRITE_NS = WRITE_TIME_NS,
  parameter logic [5:0]  DEV_TYPE   = DEV_TYPE_DEF,
  parameter int unsigned FDEPTH     = FIFO_DEPTH
)
(
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic scl,
  input  wire logic sda_in,
  output var  logic sda_out,
  output var  logic sda_oe,
  input  wire logic device_select_pin,
  output var  logic standby,
  output var  logic busy
);

  localparam int unsigned T_WR_CYC = eetws_cycles(T_WRITE_NS);
  localparam int unsigned PW       = $clog2(T_WR_CYC + 1);
  localparam int unsigned FPW      = (FDEPTH > 1) ? $clog2(FDEPTH) : 1;
  localparam logic [PW-1:0] PROG_LAST = PW'(T_WR_CYC - 1);

  // pin synchronisers
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, sel_m, sel_s;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {sel_m, sel_s}        <= 2'h0;
    end
    else
    begin
      {scl_m, scl_s, scl_d} <= {scl, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
      {sel_m, sel_s}        <= {device_select_pin, sel_m};
    end
  end

  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

  eetws_state_e       state, next_state, after, next_after;
  logic [3:0]         bitcnt, next_bitcnt, fetch_cnt, next_fetch_cnt;
  logic [7:0]         shift, next_shift, addr_reg, next_addr_reg;
  logic               next_sda_oe, dirty, next_dirty, fetching, next_fetching;
  logic               host_ack, next_host_ack;
  logic [PW-1:0]      prog_cnt, next_prog_cnt;
  logic [7:0]         shadow [0:7];
  logic [7:0]         next_shadow [0:7];
  logic               mem_we;
  logic [7:0]         mem_waddr, mem_wdata, mem_raddr, mem_rdata;
  logic               push, pop, fifo_in_ready, dev_match;
  logic [7:0]         fifo_mem [0:FDEPTH-1];
  logic [FPW-1:0]     fifo_wp, fifo_rp, next_fifo_wp, next_fifo_rp;
  logic [FPW:0]       fifo_cnt, next_fifo_cnt;

  assign fifo_in_ready = (fifo_cnt != (FPW+1)'(FDEPTH));
  assign dev_match = (shift[7:2] == DEV_TYPE) && (shift[1] == sel_s);
  assign mem_raddr = fetching ? {addr_reg[7:3], fetch_cnt[2:0]} : addr_reg;

  eetws_mem u_mem (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .wr_en   (mem_we),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_addr (mem_raddr),
    .rd_data (mem_rdata)
  );

  always_comb
  begin
    next_state     = state;
    next_after     = after;
    next_bitcnt    = bitcnt;
    next_shift     = shift;
    next_addr_reg  = addr_reg;
    next_sda_oe    = sda_oe;
    next_dirty     = dirty;
    next_fetching  = fetching;
    next_fetch_cnt = fetch_cnt;
    next_host_ack  = host_ack;
    next_prog_cnt  = prog_cnt;
    next_shadow    = shadow;
    push           = 1'b0;
    pop            = 1'b0;
    mem_we         = 1'b0;
    mem_waddr      = {addr_reg[7:3], prog_cnt[2:0]};
    mem_wdata      = shadow[prog_cnt[2:0]];
    // page shadow: fetch first, then drain staged bytes
    if (fetching)
    begin
      if (fetch_cnt != 4'h0)
      begin
        next_shadow[3'(fetch_cnt - 4'h1)] = mem_rdata;
      end
      next_fetch_cnt = fetch_cnt + 4'h1;
      next_fetching  = (fetch_cnt != PAGE_BYTES);
    end
    else if (fifo_cnt != '0)
    begin
      pop = 1'b1;
      next_shadow[addr_reg[2:0]] = fifo_mem[fifo_rp];
      next_addr_reg = eetws_page_inc(addr_reg);
      next_dirty    = 1'b1;
    end
    if (state == ST_PROG)
    begin
      // programming owns the bus side; pins are not looked at
      mem_we        = (prog_cnt < PW'(PAGE_BYTES));
      next_prog_cnt = prog_cnt + PW'(1);
      if (prog_cnt == PROG_LAST)
      begin
        next_state = ST_IDLE;
        next_dirty = 1'b0;
      end
    end
    else if (start_ev)
    begin
      next_state  = ST_DEVW;
      next_bitcnt = 4'h0;
      next_sda_oe = 1'b0;
      next_dirty  = 1'b0;
    end
    else if (stop_ev)
    begin
      next_sda_oe   = 1'b0;
      next_prog_cnt = '0;
      next_state    = next_dirty ? ST_PROG : ST_IDLE;
    end
    else
    begin
      case (state)
        ST_DEVW, ST_MADDR, ST_WDATA:
        begin
          if (scl_rise && bitcnt != BYTE_BITS)
          begin
            next_shift  = {shift[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end
          else if (scl_fall && bitcnt == BYTE_BITS)
          begin
            next_bitcnt = 4'h0;
            next_state  = ST_ACK;
            next_sda_oe = 1'b1;
            if (state == ST_DEVW)
            begin
              next_after = shift[0] ? ST_RDATA : ST_MADDR;
              if (!dev_match)
              begin
                next_state  = ST_IDLE;
                next_sda_oe = 1'b0;
              end
            end
            else if (state == ST_MADDR)
            begin
              next_addr_reg  = shift;
              next_fetching  = 1'b1;
              next_fetch_cnt = 4'h0;
              next_after     = ST_WDATA;
            end
            else if (fifo_in_ready)
            begin
              push       = 1'b1;
              next_after = ST_WDATA;
            end
            else
            begin
              next_state  = ST_IDLE;
              next_sda_oe = 1'b0;
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            next_sda_oe = 1'b0;
            next_state  = after;
            if (after == ST_RDATA)
            begin
              next_shift    = mem_rdata;
              next_sda_oe   = ~mem_rdata[7];
              next_addr_reg = addr_reg + 8'h01;
              next_bitcnt   = 4'h1;
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (bitcnt == BYTE_BITS)
            begin
              next_sda_oe = 1'b0;
              next_state  = ST_RACK;
            end
            else
            begin
              next_sda_oe = ~shift[6];
              next_shift  = {shift[6:0], 1'b0};
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            next_host_ack = ~sda_s;
          end
          else if (scl_fall)
          begin
            if (host_ack)
            begin
              next_state    = ST_RDATA;
              next_shift    = mem_rdata;
              next_sda_oe   = ~mem_rdata[7];
              next_addr_reg = addr_reg + 8'h01;
              next_bitcnt   = 4'h1;
            end
            else
            begin
              next_state  = ST_IDLE;
              next_sda_oe = 1'b0;
            end
          end
        end
        default:
        begin
          next_state = state;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state     <= ST_IDLE;
      after     <= ST_IDLE;
      bitcnt    <= 4'h0;
      shift     <= 8'h00;
      addr_reg  <= 8'h00;
      sda_oe    <= 1'b0;
      sda_out   <= SDA_LOW;
      dirty     <= 1'b0;
      fetching  <= 1'b0;
      fetch_cnt <= 4'h0;
      host_ack  <= 1'b0;
      prog_cnt  <= '0;
      shadow    <= '{default: 8'h00};
      standby   <= 1'b1;
      busy      <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      after     <= next_after;
      bitcnt    <= next_bitcnt;
      shift     <= next_shift;
      addr_reg  <= next_addr_reg;
      sda_oe    <= next_sda_oe;
      sda_out   <= SDA_LOW;
      dirty     <= next_dirty;
      fetching  <= next_fetching;
      fetch_cnt <= next_fetch_cnt;
      host_ack  <= next_host_ack;
      prog_cnt  <= next_prog_cnt;
      shadow    <= next_shadow;
      standby   <= (next_state == ST_IDLE);
      busy      <= (next_state == ST_PROG);
    end
  end

  // two-entry staging buffer between byte receiver and page shadow
  always_comb
  begin
    next_fifo_wp  = push ? FPW'(fifo_wp + 1'b1) : fifo_wp;
    next_fifo_rp  = pop ? FPW'(fifo_rp + 1'b1) : fifo_rp;
    next_fifo_cnt = fifo_cnt + (FPW+1)'(push) - (FPW+1)'(pop);
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fifo_wp  <= '0;
      fifo_rp  <= '0;
      fifo_cnt <= '0;
      fifo_mem <= '{default: 8'h00};
    end
    else
    begin
      fifo_wp  <= next_fifo_wp;
      fifo_rp  <= next_fifo_rp;
      fifo_cnt <= next_fifo_cnt;
      if (push)
      begin
        fifo_mem[fifo_wp] <= shift;
      end
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_read_stop;
    (state == ST_RDATA || state == ST_RACK) ##0 stop_ev;
  endsequence
  sequence s_byte_end(eetws_state_e st);
    state == st && scl_fall && bitcnt == BYTE_BITS;
  endsequence

  start_restart_a: assert property (start_ev && state != ST_PROG |=> state == ST_DEVW && !sda_oe)
    else $error("start did not restart address matching");
  stop_end_a: assert property (stop_ev && state != ST_PROG |=> state == ST_IDLE || state == ST_PROG)
    else $error("stop did not end the transfer");
  read_standby_a: assert property (s_read_stop |=> ##1 standby)
    else $error("no standby after read stop");
  byte_ack_a: assert property (s_byte_end(ST_MADDR) |=> sda_oe ##1 sda_oe [*1] ##0 state == ST_ACK)
    else $error("memory address not acknowledged");
  mismatch_idle_a: assert property (s_byte_end(ST_DEVW) && !dev_match |=> state == ST_IDLE && !sda_oe)
    else $error("mismatched address word acknowledged");
  sda_change_a: assert property ($changed(sda_oe) && !$past(start_ev) && !$past(stop_ev) |-> !$past(scl_s))
    else $error("data driven change while clock high");
  prog_quiet_a: assert property (state == ST_PROG |=> !sda_oe && (state == ST_PROG || state == ST_IDLE))
    else $error("serial activity during programming");
  prog_cause_a: assert property ($rose(state == ST_PROG) |-> $past(stop_ev) && $past(next_dirty))
    else $error("programming without stop after data");
  page_wrap_a: assert property (pop |=> addr_reg[7:3] == $past(addr_reg[7:3]))
    else $error("write address left its page");
  read_incr_a: assert property (state == ST_RACK && scl_fall && host_ack |=> addr_reg == $past(addr_reg) + 8'h01)
    else $error("read address did not advance");
  nack_release_a: assert property (state == ST_RACK && scl_fall && !host_ack |=> !sda_oe [*2])
    else $error("data line held after master nack");

endmodule
`default_nettype wire

// file: src/eetws_unused_guard.sv
`timescale 1ns/1ps

// file: tb/eetws_master.sv
// two-wire bus master model: drives the clock pin and pulls the data wire
// assumes the bench resolves the pulled-up data wire from both pull enables
`timescale 1ns/1ps
`default_nettype none
module eetws_master
(
  input  wire logic ref_clk,
  input  wire logic sda_wire,
  output var  logic scl,
  output var  logic sda_pull,
  output var  logic last_bit
);
  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
    last_bit = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // 800 ns cell: low 5 clocks, high 3, wire sampled late in the high phase
  task automatic bit_cell(input logic b);
    tick(1);
    sda_pull <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(2);
    @(negedge ref_clk) last_bit = sda_wire;
    tick(1);
    scl <= 1'b0;
  endtask

  task automatic start_c();
    tick(1);
    sda_pull <= 1'b0;
    tick(5);
    scl <= 1'b1;
    tick(3);
    sda_pull <= 1'b1;
    tick(3);
    scl <= 1'b0;
  endtask

  task automatic stop_c();
    tick(1);
    sda_pull <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_pull <= 1'b0;
    tick(5);
  endtask

  task automatic send_bits(input logic [7:0] v, input int n);
    for (int i = 7; i > 7 - n; i--)
      bit_cell(v[i]);
  endtask

  task automatic wr_byte(input logic [7:0] v, output logic ack);
    send_bits(v, 8);
    bit_cell(1'b1);
    ack = ~last_bit;
  endtask

  task automatic rd_byte(input logic ack, output logic [7:0] v);
    for (int i = 7; i >= 0; i--)
    begin
      bit_cell(1'b1);
      v[i] = last_bit;
    end
    bit_cell(~ack);
  endtask

  // clock until the wire reads high, then a start
  task automatic recover();
    last_bit = 1'b0;
    for (int i = 0; i < 9 && last_bit !== 1'b1; i++)
      bit_cell(1'b1);
    start_c();
  endtask
endmodule
`default_nettype wire

// file: tb/eetws_slave_tb.sv
// self-checking bench for the two-wire memory slave
// assumes the master model in eetws_master.sv and a shortened write time
`timescale 1ns/1ps
`default_nettype none
module eetws_slave_tb;
  // device type code; value is arbitrary
  localparam logic [5:0] TYPE_CODE = 6'h15;

  logic       ref_clk;
  logic       rst_b;
  logic       sel_pin;
  logic       scl;
  logic       sda_pull;
  logic       sda_out;
  logic       sda_oe;
  logic       standby;
  logic       busy;
  logic       m_bit;
  wire  logic sda_wire;
  int         num_errors;
  int         n_checks;
  logic [7:0] mem_exp [256];

  assign sda_wire = ~(sda_pull | (sda_oe & ~sda_out));

  eetws_slave #(.T_WRITE_NS(20000), .DEV_TYPE(TYPE_CODE)) i_eetws_slave
  (
    .ref_clk(ref_clk), .rst_b(rst_b), .scl(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .device_select_pin(sel_pin),
    .standby(standby), .busy(busy)
  );

  eetws_master i_eetws_master
  (
    .ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl),
    .sda_pull(sda_pull), .last_bit(m_bit)
  );

  always #50 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] dw(input logic sel, input logic rw);
    return {TYPE_CODE, sel, rw};
  endfunction

  task automatic send(input logic [7:0] v, input logic exp_ack);
    logic ack;
    i_eetws_master.wr_byte(v, ack);
    chk("ack", 8'(exp_ack), 8'(ack));
  endtask

  task automatic wr_page(input logic [7:0] a, input int n, input logic [7:0] key);
    logic [7:0] p;
    i_eetws_master.start_c();
    send(dw(1'b1, 1'b0), 1'b1);
    send(a, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      p = {a[7:3], 3'(a[2:0] + i)};
      send(p ^ key, 1'b1);
      mem_exp[p] = p ^ key;
    end
    i_eetws_master.stop_c();
    @(negedge ref_clk);
    chk("busy after stop", 8'h01, 8'(busy));
  endtask

  task automatic wait_prog();
    int k;
    k = 0;
    while (busy === 1'b1 && k < 400)
    begin
      @(negedge ref_clk);
      k++;
    end
    chk("busy end", 8'h00, 8'(busy));
    chk("standby after write", 8'h01, 8'(standby));
  endtask

  task automatic rd_run(input logic [7:0] a, input int n);
    logic [7:0] v;
    for (int i = 0; i < n; i++)
    begin
      i_eetws_master.rd_byte(i < n - 1, v);
      chk("read data", mem_exp[8'(a + i)], v);
    end
    chk("released after nack", 8'h01, 8'(m_bit));
    i_eetws_master.stop_c();
    @(negedge ref_clk);
    chk("standby after read", 8'h01, 8'(standby));
  endtask

  task automatic sc_read(input logic [7:0] a, input int n);
    i_eetws_master.start_c();
    send(dw(1'b1, 1'b0), 1'b1);
    send(a, 1'b1);
    i_eetws_master.start_c();
    send(dw(1'b1, 1'b1), 1'b1);
    rd_run(a, n);
  endtask

  task automatic sc_current(input logic [7:0] a);
    i_eetws_master.start_c();
    send(dw(1'b1, 1'b1), 1'b1);
    rd_run(a, 1);
    // stop while the next byte is being sent; its msb is 1, so the line is free
    i_eetws_master.start_c();
    send(dw(1'b1, 1'b1), 1'b1);
    i_eetws_master.stop_c();
    @(negedge ref_clk);
    chk("standby after read stop", 8'h01, 8'(standby));
  endtask

  task automatic sc_pages();
    wr_page(8'h00, 8, 8'h5A);
    wait_prog();
    wr_page(8'hF8, 8, 8'h5A);
    wait_prog();
    wr_page(8'hFE, 3, 8'hC3);
    wait_prog();
  endtask

  task automatic sc_mismatch();
    for (int j = 0; j < 2; j++)
    begin
      i_eetws_master.start_c();
      send(j == 0 ? dw(1'b0, 1'b0) : {TYPE_CODE ^ 6'h01, 2'b10}, 1'b0);
      @(negedge ref_clk);
      chk("standby on mismatch", 8'h01, 8'(standby));
      i_eetws_master.stop_c();
    end
  endtask

  task automatic sc_poll();
    wr_page(8'h40, 1, 8'h77);
    i_eetws_master.start_c();
    send(dw(1'b1, 1'b0), 1'b0);
    i_eetws_master.stop_c();
    wait_prog();
    i_eetws_master.start_c();
    send(dw(1'b1, 1'b0), 1'b1);
    i_eetws_master.stop_c();
    @(negedge ref_clk);
    chk("no programming without data", 8'h00, 8'(busy));
  endtask

  task automatic sc_discard();
    i_eetws_master.start_c();
    send(dw(1'b1, 1'b0), 1'b1);
    send(8'h00, 1'b1);
    send(8'hEE, 1'b1);
    sc_read(8'h00, 1);
    chk("staged data dropped", 8'h00, 8'(busy));
  endtask

  task automatic sc_abort();
    i_eetws_master.start_c();
    i_eetws_master.send_bits(dw(1'b1, 1'b0), 5);
    sc_read(8'h02, 1);
  endtask

  initial
  begin
    #3000000;
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    ref_clk    = 1'b0;
    rst_b      = 1'b0;
    sel_pin    = 1'b1;
    num_errors = 0;
    n_checks   = 0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(negedge ref_clk);
    chk("standby at reset", 8'h01, 8'(standby));
    chk("busy at reset", 8'h00, 8'(busy));
    chk("data released at reset", 8'h00, 8'(sda_oe));
    repeat (4) @(posedge ref_clk);
    i_eetws_master.recover();
    i_eetws_master.stop_c();
    sc_pages();
    sc_read(8'hFE, 4);
    sc_read(8'hF8, 1);
    sc_current(8'hF9);
    sc_mismatch();
    sc_poll();
    sc_discard();
    sc_abort();
    report_and_stop();
  end
endmodule
`default_nettype wire
